// >>> rtl/cht_pkg.sv
// Constants, register map and carrier types of the card host transfer configuration.
// Assumes an APB master on pclk; all addresses are full 32-bit byte addresses.
//
// Behaviour
// - policy clear, block at least 3/4 FIFO: start write at half full.
// - policy clear, block at least half but below 3/4: start at quarter full.
// - policy clear, block below half FIFO: start once whole transfer, capped at a full FIFO, is buffered.
// - policy set: start write as soon as one word is in the FIFO.
// - clear policy zero: flow error flags hold until next read/write command.
// - clear policy one: flow error flags clear on status register read.
// - high speed set: line outputs change on card clock rising edge.
// - sync clear: pending command sent at end of current block.
// - sync set: pending command waits for transfer end, finite counts only.
// - configuration writes ignored while write protect enable is set.
`default_nettype none
package cht_pkg;

  // ------------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------------
  localparam logic [31:0] IRQ_STATUS_ADDR = 32'h4000_0040;
  localparam logic [31:0] IRQ_MASK_ADDR = 32'h4000_0044;
  localparam logic [31:0] FLOW_STATUS_ADDR = 32'h4000_0048;
  localparam logic [31:0] BLOCK_ADDR = 32'h4000_004C;
  localparam logic [31:0] TRANSFER_CONFIG_ADDR = 32'h4000_0054;
  localparam logic [31:0] WRITE_PROTECT_ADDR = 32'h4000_00E4;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int FIFO_START_POLICY_BIT = 0;
  localparam int FLOW_ERROR_CLEAR_POLICY_BIT = 4;
  localparam int HIGH_SPEED_TIMING_BIT = 8;
  localparam int LAST_BLOCK_SYNC_BIT = 12;
  localparam int WRITE_PROTECT_ENABLE_BIT = 0;
  localparam int IRQ_START_BIT = 0;
  localparam int IRQ_CMD_SENT_BIT = 1;
  localparam int IRQ_FLOW_BIT = 2;
  localparam int FLOW_UNDER_BIT = 0;
  localparam int FLOW_OVER_BIT = 1;
  localparam int BLOCK_LEN_LSB = 0;
  localparam int BLOCK_COUNT_LSB = 16;

  // ------------------------------------------------------------------
  // reset values and sizes
  // ------------------------------------------------------------------
  localparam logic [3:0] CFG_RESET = 4'h0;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam logic [15:0] BLOCK_RESET = 16'h0000;
  localparam int FIFO_DEPTH_WORDS = 256;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic last_block_sync;
    logic high_speed_timing;
    logic flow_error_clear_policy;
    logic fifo_start_policy;
  } cht_cfg_type;

  typedef struct packed {
    logic cmd;
    logic [3:0] dat;
  } cht_line_type;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_IRQ_STATUS,
    SEL_IRQ_MASK,
    SEL_FLOW,
    SEL_BLOCK,
    SEL_CFG,
    SEL_WP
  } cht_sel_type;

endpackage
`default_nettype wire

// >>> rtl/cht_start_gate.sv
// Write start threshold: decides whether the FIFO holds enough to start a write.
// Assumes fifo_level counts words on the pclk domain; purely combinational.
`default_nettype none
module cht_start_gate
  import cht_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH_WORDS,
  parameter int LW = $clog2(DEPTH) + 1
) (
  // configuration
  input wire logic policy,
  input wire logic [15:0] block_len,
  input wire logic [15:0] block_count,
  // fifo state
  input wire logic [LW-1:0] fifo_level,
  // decision
  output logic start_ok
);

  localparam logic [31:0] THREE_QUARTER = 32'((3 * DEPTH) / 4);
  localparam logic [31:0] HALF = 32'(DEPTH / 2);
  localparam logic [31:0] QUARTER = 32'(DEPTH / 4);

  logic [31:0] level;
  logic [31:0] blen;
  logic [31:0] total;

  // threshold selection by block length
  always_comb begin
    level = 32'(fifo_level);
    blen = {16'h0000, block_len};
    total = (block_count == 16'h0000) ? blen : blen * {16'h0000, block_count};
    if (total > 32'(DEPTH)) begin
      total = 32'(DEPTH);
    end
    if (policy) begin
      start_ok = (level >= 32'h0000_0001);
    end else if (blen >= THREE_QUARTER) begin
      start_ok = (level >= HALF);
    end else if (blen >= HALF) begin
      start_ok = (level >= QUARTER);
    end else begin
      start_ok = (level >= total) && (total != 32'h0000_0000);
    end
  end

endmodule
`default_nettype wire

// >>> rtl/cht_line_drive.sv
// Command and data line driver timed from the card clock seen through a synchroniser.
// Assumes card_clk is an outside level far slower than pclk.
`default_nettype none
module cht_line_drive
  import cht_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // card clock pin and mode
  input wire logic card_clk,
  input wire logic high_speed_timing,
  // line values
  input wire cht_line_type line_next,
  output cht_line_type line_out
);

  logic sync_a;
  logic sync_b;
  logic clk_prev;
  logic rise;
  logic fall;
  cht_line_type next_line_out;

  // two flop synchroniser and edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      clk_prev <= 1'b0;
      line_out <= '1;
    end else begin
      sync_a <= card_clk;
      sync_b <= sync_a;
      clk_prev <= sync_b;
      line_out <= next_line_out;
    end
  end

  assign rise = sync_b && !clk_prev;
  assign fall = !sync_b && clk_prev;

  always_comb begin
    next_line_out = line_out;
    if (high_speed_timing ? rise : fall) begin
      next_line_out = line_next;
    end
  end

  a_hs_launch: assert property (@(posedge pclk) disable iff (!presetn)
    (high_speed_timing && $past(high_speed_timing) && line_out != $past(line_out))
      |-> $past(rise))
    else $error("line changed away from card clock rise in high speed");

endmodule
`default_nettype wire

// >>> rtl/cht_transfer_config.sv
// Transfer configuration top: APB registers, write start, flow flags, command issue.
// Assumes core events arrive on pclk as one-cycle pulses; card_clk is asynchronous.
//
// Design decision made here: the APB interface to the registers.
`default_nettype none
module cht_transfer_config
  import cht_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH_WORDS,
  parameter int LW = $clog2(DEPTH) + 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // fifo and write transfer
  input wire logic [LW-1:0] fifo_level,
  input wire logic write_request,
  output logic write_start,
  // flow errors and commands
  input wire logic underflow_event,
  input wire logic overflow_event,
  input wire logic new_rw_command,
  input wire logic cmd_pending,
  input wire logic block_end,
  input wire logic transfer_end,
  output logic cmd_send,
  // card lines
  input wire logic card_clk,
  input wire cht_line_type line_next,
  output cht_line_type line_out,
  // interrupt
  output logic irq
);

  // ------------------------------------------------------------------
  // register state
  // ------------------------------------------------------------------
  cht_cfg_type cfg;
  cht_cfg_type next_cfg;
  logic wp_en;
  logic next_wp_en;
  logic [2:0] irq_mask;
  logic [2:0] next_irq_mask;
  logic [2:0] irq_status;
  logic [2:0] next_irq_status;
  logic [1:0] flow;
  logic [1:0] next_flow;
  logic [15:0] block_len;
  logic [15:0] next_block_len;
  logic [15:0] block_count;
  logic [15:0] next_block_count;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic write_pending;
  logic next_write_pending;
  logic next_write_start;
  logic next_cmd_send;
  logic start_ok;
  logic setup;
  logic access;
  logic wr_fire;
  logic rd_fire;
  logic cmd_due;
  cht_sel_type sel;

  // address decode to a register select
  function automatic cht_sel_type decode(input logic [31:0] addr);
    if (addr == IRQ_STATUS_ADDR) begin
      return SEL_IRQ_STATUS;
    end else if (addr == IRQ_MASK_ADDR) begin
      return SEL_IRQ_MASK;
    end else if (addr == FLOW_STATUS_ADDR) begin
      return SEL_FLOW;
    end else if (addr == BLOCK_ADDR) begin
      return SEL_BLOCK;
    end else if (addr == TRANSFER_CONFIG_ADDR) begin
      return SEL_CFG;
    end else if (addr == WRITE_PROTECT_ADDR) begin
      return SEL_WP;
    end else begin
      return SEL_NONE;
    end
  endfunction

  function automatic logic [31:0] cfg_word(input cht_cfg_type c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[FIFO_START_POLICY_BIT] = c.fifo_start_policy;
    w[FLOW_ERROR_CLEAR_POLICY_BIT] = c.flow_error_clear_policy;
    w[HIGH_SPEED_TIMING_BIT] = c.high_speed_timing;
    w[LAST_BLOCK_SYNC_BIT] = c.last_block_sync;
    return w;
  endfunction

  // ------------------------------------------------------------------
  // bus phases
  // ------------------------------------------------------------------
  // zero wait states: read data is captured in the setup cycle
  assign sel = decode(paddr);
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign pready = 1'b1;
  assign wr_fire = access && pwrite;
  assign rd_fire = access && !pwrite;

  // ------------------------------------------------------------------
  // write start threshold
  // ------------------------------------------------------------------
  cht_start_gate #(
    .DEPTH(DEPTH),
    .LW(LW)
  ) u_start_gate (
    .policy(cfg.fifo_start_policy),
    .block_len(block_len),
    .block_count(block_count),
    .fifo_level(fifo_level),
    .start_ok(start_ok)
  );

  // ------------------------------------------------------------------
  // card line timing
  // ------------------------------------------------------------------
  cht_line_drive u_line_drive (
    .pclk(pclk),
    .presetn(presetn),
    .card_clk(card_clk),
    .high_speed_timing(cfg.high_speed_timing),
    .line_next(line_next),
    .line_out(line_out)
  );

  // last block sync only for finite counts
  assign cmd_due = (cfg.last_block_sync && block_count != 16'h0000) ? transfer_end : block_end;

  // next values of registers, flags and pulses
  always_comb begin
    next_cfg = cfg;
    next_wp_en = wp_en;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    next_flow = flow;
    next_block_len = block_len;
    next_block_count = block_count;
    next_prdata = prdata;
    next_pslverr = pslverr;
    // read data and error prepared in setup
    if (setup) begin
      next_pslverr = (sel == SEL_NONE);
      next_prdata = 32'h0000_0000;
      if (!pwrite) begin
        case (sel)
          SEL_IRQ_STATUS: next_prdata = {29'h0, irq_status};
          SEL_IRQ_MASK: next_prdata = {29'h0, irq_mask};
          SEL_FLOW: next_prdata = {30'h0, flow};
          SEL_BLOCK: next_prdata = {block_count, block_len};
          SEL_CFG: next_prdata = cfg_word(cfg);
          SEL_WP: next_prdata = {31'h0, wp_en};
          default: next_prdata = 32'h0000_0000;
        endcase
      end
    end
    if (wr_fire) begin
      if (sel == SEL_CFG) begin
        if (!wp_en) begin
          next_cfg.fifo_start_policy = pwdata[FIFO_START_POLICY_BIT];
          next_cfg.flow_error_clear_policy = pwdata[FLOW_ERROR_CLEAR_POLICY_BIT];
          next_cfg.high_speed_timing = pwdata[HIGH_SPEED_TIMING_BIT];
          next_cfg.last_block_sync = pwdata[LAST_BLOCK_SYNC_BIT];
        end
      end else if (sel == SEL_WP) begin
        next_wp_en = pwdata[WRITE_PROTECT_ENABLE_BIT];
      end else if (sel == SEL_IRQ_MASK) begin
        next_irq_mask = pwdata[2:0];
      end else if (sel == SEL_BLOCK) begin
        next_block_len = pwdata[BLOCK_LEN_LSB +: 16];
        next_block_count = pwdata[BLOCK_COUNT_LSB +: 16];
      end else if (sel == SEL_IRQ_STATUS) begin
        next_irq_status = irq_status & ~pwdata[2:0];
      end
    end
    // cleared by a new command under policy zero, by a status read under policy one
    if (!cfg.flow_error_clear_policy && new_rw_command) begin
      next_flow = 2'b00;
    end
    if (cfg.flow_error_clear_policy && rd_fire && sel == SEL_FLOW) begin
      next_flow = 2'b00;
    end
    // set wins over any clear
    if (underflow_event) begin
      next_flow[FLOW_UNDER_BIT] = 1'b1;
    end
    if (overflow_event) begin
      next_flow[FLOW_OVER_BIT] = 1'b1;
    end
    // write start from a pending request
    next_write_start = write_pending && start_ok;
    next_write_pending = (write_pending && !start_ok) || write_request;
    next_cmd_send = cmd_pending && cmd_due;
    if (next_write_start) begin
      next_irq_status[IRQ_START_BIT] = 1'b1;
    end
    if (next_cmd_send) begin
      next_irq_status[IRQ_CMD_SENT_BIT] = 1'b1;
    end
    if (underflow_event || overflow_event) begin
      next_irq_status[IRQ_FLOW_BIT] = 1'b1;
    end
  end

  // register all state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= CFG_RESET;
      wp_en <= 1'b0;
      irq_mask <= IRQ_RESET;
      irq_status <= IRQ_RESET;
      flow <= 2'b00;
      block_len <= BLOCK_RESET;
      block_count <= BLOCK_RESET;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      write_pending <= 1'b0;
      write_start <= 1'b0;
      cmd_send <= 1'b0;
    end else begin
      cfg <= next_cfg;
      wp_en <= next_wp_en;
      irq_mask <= next_irq_mask;
      irq_status <= next_irq_status;
      flow <= next_flow;
      block_len <= next_block_len;
      block_count <= next_block_count;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      write_pending <= next_write_pending;
      write_start <= next_write_start;
      cmd_send <= next_cmd_send;
    end
  end

  // level interrupt from unmasked sticky bits
  assign irq = |(irq_status & irq_mask);

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  a_cfg_wp_block: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_fire && sel == SEL_CFG && wp_en) |=> $stable(cfg))
    else $error("config changed while write protected");

  a_cfg_bit_map: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_fire && sel == SEL_CFG && !wp_en)
      |=> cfg_word(cfg) == ($past(pwdata) & 32'h0000_1111))
    else $error("config fields not stored at their bit positions");

  a_start_single: assert property (@(posedge pclk) disable iff (!presetn)
    (write_pending && cfg.fifo_start_policy && fifo_level != '0) |=> write_start)
    else $error("write did not start on a single word");

  a_start_half: assert property (@(posedge pclk) disable iff (!presetn)
    (write_pending && !cfg.fifo_start_policy && 32'(block_len) >= 32'((3 * DEPTH) / 4))
      |=> (write_start == ($past(32'(fifo_level)) >= 32'(DEPTH / 2))))
    else $error("half fifo start threshold wrong");

  a_start_quarter: assert property (@(posedge pclk) disable iff (!presetn)
    (write_pending && !cfg.fifo_start_policy && 32'(block_len) >= 32'(DEPTH / 2)
      && 32'(block_len) < 32'((3 * DEPTH) / 4))
      |=> (write_start == ($past(32'(fifo_level)) >= 32'(DEPTH / 4))))
    else $error("quarter fifo start threshold wrong");

  a_start_total: assert property (@(posedge pclk) disable iff (!presetn)
    (write_pending && !cfg.fifo_start_policy && block_count == 16'h0001
      && block_len != 16'h0000 && 32'(block_len) < 32'(DEPTH / 2))
      |=> (write_start == ($past(32'(fifo_level)) >= $past(32'(block_len)))))
    else $error("whole transfer start threshold wrong");

  a_flow_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (!cfg.flow_error_clear_policy && !new_rw_command && flow != 2'b00)
      |=> (flow & $past(flow)) == $past(flow))
    else $error("flow flag dropped without a new command");

  a_flow_read_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg.flow_error_clear_policy && rd_fire && sel == SEL_FLOW
      && !underflow_event && !overflow_event) |=> flow == 2'b00)
    else $error("flow flag not cleared by status read");

  a_cmd_block: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_pending && !cfg.last_block_sync) |=> (cmd_send == $past(block_end)))
    else $error("pending command not sent at block end");

  a_cmd_last: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_pending && cfg.last_block_sync && block_count != 16'h0000)
      |=> (cmd_send == $past(transfer_end)))
    else $error("pending command not held to transfer end");

endmodule
`default_nettype wire

// >>> rtl/_unused_never.sv
`default_nettype none
`default_nettype wire

// >>> verification/cht_card_model.sv
// Memory card model: makes the card clock within frames and samples the host lines.
// Assumes the host launches its lines well ahead of the card clock rising edge.
`default_nettype none
module cht_card_model
  import cht_pkg::*;
(
  // frame control
  input wire logic run,
  // host lines and card clock
  input wire cht_line_type line_out,
  output logic card_clk,
  output cht_line_type sampled
);
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------------
  // card clock
  // ------------------------------------------------------------------
  // 80 ns period; stands low between frames, phase off the host grid
  initial card_clk = 1'h0;
  always begin
    wait (run);
    #37 card_clk = 1'h1;
    #40 card_clk = 1'h0;
    #3;
  end

  // card takes the lines on its rising edge
  always @(posedge card_clk) sampled <= line_out;
endmodule
`default_nettype wire

// >>> verification/cht_transfer_config_bench.sv
// Self-checking bench of the transfer configuration block over APB.
// Assumes the card model beside it; expectations come from bench functions.
`default_nettype none
module cht_transfer_config_bench
  import cht_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, cmd_pending = 1'h0, run = 1'h0, err;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, rd, d;
  logic [8:0] fifo_level = 9'h0;
  logic [5:0] ev = 6'h0;
  cht_line_type line_v = 5'h00, v, v2;
  logic [31:0] prdata;
  logic pready, pslverr, write_start, cmd_send, irq, card_clk;
  cht_line_type line_out, sampled;
  int n_mismatch = 0, comparisons = 0, n_start = 0, n_cmd = 0, seed, i;

  always #5 pclk = ~pclk;

  // counts of one-cycle output pulses
  always @(posedge pclk) begin
    if (write_start === 1'h1) n_start <= n_start + 1;
    if (cmd_send === 1'h1) n_cmd <= n_cmd + 1;
  end

  cht_transfer_config uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fifo_level(fifo_level), .write_request(ev[0]), .write_start(write_start),
    .underflow_event(ev[1]), .overflow_event(ev[2]), .new_rw_command(ev[3]),
    .cmd_pending(cmd_pending), .block_end(ev[4]), .transfer_end(ev[5]),
    .cmd_send(cmd_send), .card_clk(card_clk), .line_next(line_v), .line_out(line_out),
    .irq(irq)
  );

  cht_card_model card (.run(run), .line_out(line_out), .card_clk(card_clk), .sampled(sampled));

  // ------------------------------------------------------------------
  // tasks and functions
  // ------------------------------------------------------------------
  task summarize();
    if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task fail(input string name);
    n_mismatch++;
    $display("MISMATCH %s expected answer seen timeout", name);
    summarize();
  endtask

  // one apb transfer; request held until pready is sampled high
  task apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    if (k == 16) fail("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task rd_chk(input string n, input logic [31:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    check(n, exp, rd);
  endtask

  // one-cycle pulse on an event input
  task pulse(input int b);
    @(posedge pclk);
    ev[b] <= 1'h1;
    @(posedge pclk);
    ev[b] <= 1'h0;
  endtask

  // fifo level at which a write may start
  function automatic int exp_thr(logic pol, int len, int cnt);
    int tot;
    tot = len * ((cnt == 0) ? 1 : cnt);
    if (pol) return 1;
    if (len >= FIFO_DEPTH_WORDS * 3 / 4) return FIFO_DEPTH_WORDS / 2;
    if (len >= FIFO_DEPTH_WORDS / 2) return FIFO_DEPTH_WORDS / 4;
    return (tot > FIFO_DEPTH_WORDS) ? FIFO_DEPTH_WORDS : tot;
  endfunction

  task start_case(input logic pol, input int len, input int cnt);
    int thr, s, k;
    thr = exp_thr(pol, len, cnt);
    apb(1'h1, TRANSFER_CONFIG_ADDR, {31'h0, pol});
    apb(1'h1, BLOCK_ADDR, {cnt[15:0], len[15:0]});
    fifo_level <= 9'(thr - 1);
    pulse(0);
    s = n_start;
    repeat (6) @(posedge pclk);
    check("write_start early", s, n_start);
    fifo_level <= 9'(thr);
    for (k = 0; k < 8 && n_start == s; k++) @(posedge pclk);
    check("write_start", s + 1, n_start);
    fifo_level <= 9'h0;
  endtask

  task cmd_case(input logic sync, input int cnt, input int b, input int exp);
    int s;
    apb(1'h1, TRANSFER_CONFIG_ADDR, {19'h0, sync, 12'h0});
    apb(1'h1, BLOCK_ADDR, {cnt[15:0], 16'h0010});
    cmd_pending <= 1'h1;
    s = n_cmd;
    pulse(b);
    repeat (3) @(posedge pclk);
    cmd_pending <= 1'h0;
    check("cmd_send", s + exp, n_cmd);
  endtask

  task wait_cclk(input logic lvl);
    int k;
    for (k = 0; k < 100 && card_clk !== lvl; k++) #1;
    if (k == 100) fail("card_clk");
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    seed = $urandom(32'hD22D);
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    // reset values and an unmapped place
    rd_chk("config reset", TRANSFER_CONFIG_ADDR, 32'h0);
    rd_chk("mask reset", IRQ_MASK_ADDR, 32'h0);
    apb(1'h0, 32'h4000_0050, 32'h0);
    check("unmapped pslverr", 32'h1, {31'h0, err});
    apb(1'h1, 32'h4000_0050, 32'hFFFF_FFFF);
    check("unmapped write pslverr", 32'h1, {31'h0, err});
    // config layout, then write protection
    for (i = 0; i < 4; i++) begin
      d = $urandom;
      apb(1'h1, TRANSFER_CONFIG_ADDR, d);
      rd_chk("config", TRANSFER_CONFIG_ADDR, d & 32'h1111);
    end
    apb(1'h1, WRITE_PROTECT_ADDR, 32'h1);
    rd_chk("write protect", WRITE_PROTECT_ADDR, 32'h1);
    apb(1'h1, TRANSFER_CONFIG_ADDR, ~d);
    rd_chk("config protected", TRANSFER_CONFIG_ADDR, d & 32'h1111);
    apb(1'h1, WRITE_PROTECT_ADDR, 32'h0);
    apb(1'h1, TRANSFER_CONFIG_ADDR, ~d);
    rd_chk("config open", TRANSFER_CONFIG_ADDR, ~d & 32'h1111);
    // write start thresholds: corners, then random
    start_case(1'h0, 192, 1);
    start_case(1'h0, 191, 1);
    start_case(1'h0, 128, 0);
    start_case(1'h0, 127, 1);
    start_case(1'h0, 20, 3);
    start_case(1'h0, 100, 5);
    start_case(1'h1, 200, 2);
    for (i = 0; i < 4; i++) start_case(1'($urandom), 1 + $urandom % 299, $urandom % 4);
    // flow flags and the interrupt
    apb(1'h1, IRQ_STATUS_ADDR, 32'h7);
    apb(1'h1, IRQ_MASK_ADDR, 32'h4);
    apb(1'h1, TRANSFER_CONFIG_ADDR, 32'h0);
    pulse(1);
    @(negedge pclk);
    check("irq raised", 32'h1, {31'h0, irq});
    rd_chk("flow held", FLOW_STATUS_ADDR, 32'h1);
    rd_chk("flow held", FLOW_STATUS_ADDR, 32'h1);
    pulse(3);
    rd_chk("flow cleared", FLOW_STATUS_ADDR, 32'h0);
    rd_chk("irq status", IRQ_STATUS_ADDR, 32'h4);
    apb(1'h1, IRQ_STATUS_ADDR, 32'h4);
    @(negedge pclk);
    check("irq cleared", 32'h0, {31'h0, irq});
    apb(1'h1, TRANSFER_CONFIG_ADDR, 32'h10);
    apb(1'h1, IRQ_MASK_ADDR, 32'h0);
    pulse(2);
    rd_chk("flow read", FLOW_STATUS_ADDR, 32'h2);
    rd_chk("flow read clear", FLOW_STATUS_ADDR, 32'h0);
    check("irq masked", 32'h0, {31'h0, irq});
    // pending command issue
    cmd_case(1'h0, 1, 5, 0);
    cmd_case(1'h0, 1, 4, 1);
    cmd_case(1'h1, 2, 4, 0);
    cmd_case(1'h1, 2, 5, 1);
    cmd_case(1'h1, 0, 4, 1);
    // command sent and flow error stay sticky; block word reads back
    rd_chk("irq status cmd", IRQ_STATUS_ADDR, 32'h6);
    rd_chk("block", BLOCK_ADDR, 32'h0000_0010);
    // line launch edge, fast then default timing
    v = 5'($urandom);
    v2 = ~v;
    apb(1'h1, TRANSFER_CONFIG_ADDR, 32'h100);
    line_v <= v;
    run <= 1'h1;
    wait_cclk(1'h1);
    repeat (5) @(posedge pclk);
    @(negedge pclk);
    check("line_out fast", {27'h0, v}, {27'h0, line_out});
    @(posedge pclk);
    run <= 1'h0;
    repeat (12) @(posedge pclk);
    line_v <= v2;
    apb(1'h1, TRANSFER_CONFIG_ADDR, 32'h0);
    run <= 1'h1;
    wait_cclk(1'h1);
    repeat (5) @(posedge pclk);
    @(negedge pclk);
    check("line_out held", {27'h0, v}, {27'h0, line_out});
    wait_cclk(1'h0);
    repeat (5) @(posedge pclk);
    @(negedge pclk);
    check("line_out default", {27'h0, v2}, {27'h0, line_out});
    wait_cclk(1'h1);
    #1;
    check("card sample", {27'h0, v2}, {27'h0, sampled});
    @(posedge pclk);
    run <= 1'h0;
    // mid-run reset: registers and lines back to idle
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    check("line_out reset", 32'h1F, {27'h0, line_out});
    rd_chk("config after reset", TRANSFER_CONFIG_ADDR, 32'h0);
    rd_chk("write protect reset", WRITE_PROTECT_ADDR, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
